// *** verilog/rtes_top.sv ***
`timescale 1ns/100ps
module rtes_top #(
   parameter int RATE_W = 16                    // Rate sample width
) (
   input  wire logic                     pclk,       // APB clock, 20 MHz
   input  wire logic                     presetn,    // Async reset, active low
   input  wire logic [7:0]               paddr,      // APB byte address
   input  wire logic                     psel,       // APB select
   input  wire logic                     penable,    // APB enable
   input  wire logic                     pwrite,     // APB direction
   input  wire logic [31:0]              pwdata,     // APB write data
   output logic      [31:0]              prdata,     // APB read data
   output logic                          pready,     // APB ready
   output logic                          pslverr,    // APB error
   input  wire logic [1:0]               op_mode,    // Operating mode
   input  wire logic                     sample_stb, // One pulse per output sample
   input  wire logic signed [RATE_W-1:0] rate_x,     // X rate sample
   input  wire logic signed [RATE_W-1:0] rate_y,     // Y rate sample
   input  wire logic signed [RATE_W-1:0] rate_z,     // Z rate sample
   output logic                          irq         // Level interrupt
);
   localparam int NAX = 3;

   initial begin
      if (RATE_W < 16 || RATE_W > 24) $error("rtes_top: RATE_W out of range");
   end

   // Register hit on an aligned word
   function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
      reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   // Software registers
   logic [rtes_pkg::CFG_W-1:0] cfg_ff;
   logic [7:0]                 lim_ff;
   logic [7:0]                 dbl_ff;
   logic [NAX-1:0]             irq_stat_ff;
   logic [NAX-1:0]             irq_mask_ff;
   logic [NAX-1:0]             trip_q_ff;
   logic [31:0]                prdata_ff;
   logic [7:0]                 src_word;
   logic [31:0]                rd_mux;
   logic [NAX-1:0]             trip_vec;
   logic [NAX-1:0]             sign_vec;
   logic                       restart;

   // Address decode
   wire sel_cfg   = reg_hit(paddr, rtes_pkg::IDX_CONFIG);
   wire sel_src   = reg_hit(paddr, rtes_pkg::IDX_SOURCE);
   wire sel_lim   = reg_hit(paddr, rtes_pkg::IDX_LIMIT);
   wire sel_dbl   = reg_hit(paddr, rtes_pkg::IDX_DEBOUNCE);
   wire sel_istat = reg_hit(paddr, rtes_pkg::IDX_IRQ_STATUS);
   wire sel_imask = reg_hit(paddr, rtes_pkg::IDX_IRQ_MASK);
   wire mapped    = sel_cfg | sel_src | sel_lim | sel_dbl | sel_istat | sel_imask;

   // Transfer phases; slave answers in the first access cycle
   wire setup     = psel & ~penable;
   wire access    = psel & penable;
   wire acc_wr    = access & pwrite & mapped;
   wire acc_rd    = access & ~pwrite & mapped;
   wire src_rd    = acc_rd & sel_src;

   // Configuration fields
   wire hold_on   = cfg_ff[rtes_pkg::CFG_HOLD_BIT];
   wire style     = lim_ff[rtes_pkg::LIM_STYLE_BIT];
   wire [6:0] code = lim_ff[rtes_pkg::LIM_CODE_W-1:0];

   // Entry into active mode
   rtes_mode_watch u_watch (
      .pclk    (pclk),
      .presetn (presetn),
      .op_mode (op_mode),
      .restart (restart)
   );

   // One detector per axis: 0 is X, 1 is Y, 2 is Z
   rtes_axis_if #(.RATE_W(RATE_W)) ax_if [NAX] ();
   wire signed [RATE_W-1:0] rate_vec [NAX];
   assign rate_vec[0] = rate_x;
   assign rate_vec[1] = rate_y;
   assign rate_vec[2] = rate_z;

   genvar g;
   generate
      for (g = 0; g < NAX; g++) begin : g_axis
         assign ax_if[g].sample_stb = sample_stb;
         assign ax_if[g].restart    = restart;
         assign ax_if[g].rd_clr     = src_rd;
         assign ax_if[g].hold_on    = hold_on;
         assign ax_if[g].detect_on  = cfg_ff[rtes_pkg::CFG_DETECT_BASE + g];
         assign ax_if[g].style      = style;
         assign ax_if[g].length     = dbl_ff;
         assign ax_if[g].code       = code;
         assign ax_if[g].rate       = rate_vec[g];
         assign trip_vec[g]         = ax_if[g].trip;
         assign sign_vec[g]         = ax_if[g].sign;

         rtes_axis #(.RATE_W(RATE_W)) u_axis (
            .pclk    (pclk),
            .presetn (presetn),
            .ax      (ax_if[g])
         );
      end
   endgenerate

   // Source register image; bit 7 stays zero
   always_comb begin
      src_word = rtes_pkg::RST_SOURCE;
      for (int i = 0; i < NAX; i++) begin
         src_word[rtes_pkg::SRC_SIGN_BASE + rtes_pkg::SRC_STRIDE*i] = sign_vec[i];
         src_word[rtes_pkg::SRC_TRIP_BASE + rtes_pkg::SRC_STRIDE*i] = trip_vec[i];
      end
      src_word[rtes_pkg::SRC_ANY_BIT] = |trip_vec;
   end

   // Read selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_cfg) begin
         rd_mux[rtes_pkg::CFG_W-1:0] = cfg_ff;
      end
      if (sel_src) begin
         rd_mux[7:0] = src_word;
      end
      if (sel_lim) begin
         rd_mux[7:0] = lim_ff;
      end
      if (sel_dbl) begin
         rd_mux[7:0] = dbl_ff;
      end
      if (sel_istat) begin
         rd_mux[NAX-1:0] = irq_stat_ff;
      end
      if (sel_imask) begin
         rd_mux[NAX-1:0] = irq_mask_ff;
      end
   end

   // Read data captured in setup, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_ff <= rd_mux;
      end
   end

   // Configuration writes; source register ignores writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= rtes_pkg::RST_CONFIG;
         lim_ff <= rtes_pkg::RST_LIMIT;
         dbl_ff <= rtes_pkg::RST_DEBOUNCE;
      end else if (acc_wr) begin
         if (sel_cfg) begin
            cfg_ff <= pwdata[rtes_pkg::CFG_W-1:0];
         end
         if (sel_lim) begin
            lim_ff <= pwdata[7:0];
         end
         if (sel_dbl) begin
            dbl_ff <= pwdata[7:0];
         end
      end
   end

   // Interrupt events: rising edge of any axis trip
   wire [NAX-1:0] trip_rise = trip_vec & ~trip_q_ff;
   wire [NAX-1:0] w1c       = (acc_wr && sel_istat) ? pwdata[NAX-1:0] : '0;
   wire [NAX-1:0] nxt_stat  = trip_rise | (irq_stat_ff & ~w1c);

   // Sticky status with set winning over clear, and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_q_ff   <= rtes_pkg::RST_IRQ;
         irq_stat_ff <= rtes_pkg::RST_IRQ;
         irq_mask_ff <= rtes_pkg::RST_IRQ;
      end else begin
         trip_q_ff   <= trip_vec;
         irq_stat_ff <= nxt_stat;
         if (acc_wr && sel_imask) begin
            irq_mask_ff <= pwdata[NAX-1:0];
         end
      end
   end

   // Bus answers
   assign prdata  = prdata_ff;
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign irq     = |(irq_stat_ff & irq_mask_ff);

endmodule // rtes_top

// *** verilog/rtes_pkg.sv ***
package rtes_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CONFIG     = 6'h0e;
   localparam logic [5:0] IDX_SOURCE     = 6'h0f;
   localparam logic [5:0] IDX_LIMIT      = 6'h10;
   localparam logic [5:0] IDX_DEBOUNCE   = 6'h11;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK   = 6'h21;

   // Values after reset
   localparam logic [3:0] RST_CONFIG   = 4'h0;
   localparam logic [7:0] RST_LIMIT    = 8'h00;
   localparam logic [7:0] RST_DEBOUNCE = 8'h01;
   localparam logic [2:0] RST_IRQ      = 3'h0;
   localparam logic [7:0] RST_SOURCE   = 8'h00;

   // Config field positions (detect enables sit at bits 0..2 per axis)
   localparam int unsigned CFG_DETECT_BASE = 0;
   localparam int unsigned CFG_HOLD_BIT    = 3;
   localparam int unsigned CFG_W           = 4;

   // Limit register fields
   localparam int unsigned LIM_STYLE_BIT = 7;
   localparam int unsigned LIM_CODE_W    = 7;
   localparam int unsigned LIMIT_SHIFT   = 8;   // Threshold is (code + 1) * 256

   // Source register fields: sign at 2*axis, trip at 2*axis+1
   localparam int unsigned SRC_SIGN_BASE = 0;
   localparam int unsigned SRC_TRIP_BASE = 1;
   localparam int unsigned SRC_STRIDE    = 2;
   localparam int unsigned SRC_ANY_BIT   = 6;

   // Operating modes presented on op_mode
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'h0,
      MODE_READY   = 2'h1,
      MODE_ACTIVE  = 2'h2
   } rtes_mode_t;

   // Mode watcher states
   typedef enum logic [1:0] {
      WATCH_IDLE = 2'b01,
      WATCH_RUN  = 2'b10
   } rtes_watch_t;

endpackage

// *** verilog/rtes_axis_if.sv ***
`timescale 1ns/100ps
// Per-axis control and result bundle between the top and one detector
interface rtes_axis_if #(parameter int RATE_W = 16);
   logic                     sample_stb;
   logic                     restart;
   logic                     rd_clr;
   logic                     hold_on;
   logic                     detect_on;
   logic                     style;
   logic [7:0]               length;
   logic [6:0]               code;
   logic signed [RATE_W-1:0] rate;
   logic                     trip;
   logic                     sign;

   modport ctrl (output sample_stb, restart, rd_clr, hold_on, detect_on, style,
                 output length, code, rate, input trip, sign);
   modport axis (input sample_stb, restart, rd_clr, hold_on, detect_on, style,
                 input length, code, rate, output trip, sign);
endinterface

// *** verilog/rtes_mode_watch.sv ***
`timescale 1ns/100ps
module rtes_mode_watch (
   input  wire logic       pclk,     // Bus clock
   input  wire logic       presetn,  // Async reset, active low
   input  wire logic [1:0] op_mode,  // Current operating mode
   output logic            restart   // Pulse on entry to active
);
   rtes_pkg::rtes_watch_t state_ff;
   rtes_pkg::rtes_watch_t nxt_state;
   logic                  is_active;

   assign is_active = (op_mode == rtes_pkg::MODE_ACTIVE);

   // Standby or ready going to active restarts detection
   always_comb begin
      nxt_state = state_ff;
      restart   = 1'b0;
      case (state_ff)
         rtes_pkg::WATCH_IDLE: begin
            if (is_active) begin
               nxt_state = rtes_pkg::WATCH_RUN;
               restart   = 1'b1;
            end
         end
         rtes_pkg::WATCH_RUN: begin
            if (!is_active) begin
               nxt_state = rtes_pkg::WATCH_IDLE;
            end
         end
         default: nxt_state = rtes_pkg::WATCH_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= rtes_pkg::WATCH_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
endmodule // rtes_mode_watch

// *** verilog/rtes_axis.sv ***
`timescale 1ns/100ps
module rtes_axis #(
   parameter int RATE_W = 16          // Rate sample width
) (
   input  wire logic pclk,            // Bus clock
   input  wire logic presetn,         // Async reset, active low
   rtes_axis_if.axis ax               // Controls and results
);
   initial begin
      if (RATE_W < 16 || RATE_W > 24) $error("rtes_axis: RATE_W out of range");
   end

   logic [7:0]      cnt_ff;
   logic [7:0]      nxt_cnt;
   logic            live_ff;
   logic            nxt_live;
   logic            trip_ff;
   logic            sign_ff;
   wire             neg  = ax.rate[RATE_W-1];
   wire [RATE_W:0]  ext  = {neg, ax.rate};
   wire [RATE_W:0]  mag  = neg ? (RATE_W+1)'(-ext) : ext;
   wire [RATE_W:0]  lim  = ((RATE_W+1)'(ax.code) + (RATE_W+1)'(1)) << rtes_pkg::LIMIT_SHIFT;
   wire             above = (mag > lim);
   wire             clear = ax.restart | ~ax.detect_on;

   // Debounce counter, one step per output sample
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_live = live_ff;
      if (ax.sample_stb) begin
         if (above) begin
            nxt_cnt  = (cnt_ff < ax.length) ? cnt_ff + 8'h01 : cnt_ff;
            nxt_live = live_ff | (nxt_cnt >= ax.length);
         end else begin
            nxt_cnt  = ax.style ? 8'h00 : ((cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00);
            nxt_live = live_ff & (nxt_cnt != 8'h00);
         end
      end
   end

   wire rise     = nxt_live & ~live_ff;
   wire nxt_trip = ax.hold_on ? (rise | (trip_ff & ~ax.rd_clr)) : nxt_live;
   wire samp_neg = ax.sample_stb & neg;
   wire nxt_sign = ax.hold_on ? (samp_neg | (sign_ff & ~ax.rd_clr))
                              : (ax.sample_stb ? neg : sign_ff);

   // Detector state, cleared on restart or when disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff  <= 8'h00;
         live_ff <= 1'b0;
         trip_ff <= 1'b0;
         sign_ff <= 1'b0;
      end else if (clear) begin
         cnt_ff  <= 8'h00;
         live_ff <= 1'b0;
         trip_ff <= 1'b0;
         sign_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         live_ff <= nxt_live;
         trip_ff <= nxt_trip;
         sign_ff <= nxt_sign;
      end
   end

   assign ax.trip = trip_ff;
   assign ax.sign = sign_ff;
endmodule // rtes_axis

// *** tb/rtes_sva.sv ***
`timescale 1ns/100ps
// Port-level properties of the source register and the interrupt
module rtes_sva (
   input wire logic        pclk,       // Bus clock
   input wire logic        presetn,    // Reset, active low
   input wire logic [7:0]  paddr,      // Byte address
   input wire logic        psel,       // Select
   input wire logic        penable,    // Enable
   input wire logic        pwrite,     // Direction
   input wire logic [31:0] pwdata,     // Write data
   input wire logic [31:0] prdata,     // Read data
   input wire logic [1:0]  op_mode,    // Operating mode
   input wire logic        sample_stb, // Sample tick
   input wire logic        irq         // Interrupt
);
   logic [3:0] cfg_ff;
   logic [2:0] mask_ff;
   wire  logic wr_acc = psel && penable && pwrite;
   wire  logic src_rd = psel && !penable && !pwrite && paddr == 8'h3c;

   // Shadow of config and mask as written over the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff  <= 4'h0;
         mask_ff <= 3'h0;
      end else if (wr_acc && paddr == 8'h38) begin
         cfg_ff <= pwdata[3:0];
      end else if (wr_acc && paddr == 8'h84) begin
         mask_ff <= pwdata[2:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_top_zero: assert property (src_rd |=> prdata[31:7] == 25'h0)
      else $error("source upper bits not zero");
   chk_any_or: assert property (src_rd |=> prdata[6] == (prdata[5] | prdata[3] | prdata[1]))
      else $error("any-axis bit differs from axis trips");
   chk_x_gated: assert property (src_rd && !cfg_ff[0] |=> prdata[1:0] == 2'h0)
      else $error("x bits set while x detect off");
   chk_y_gated: assert property (src_rd && !cfg_ff[1] |=> prdata[3:2] == 2'h0)
      else $error("y bits set while y detect off");
   chk_z_gated: assert property (src_rd && !cfg_ff[2] |=> prdata[5:4] == 2'h0)
      else $error("z bits set while z detect off");
   chk_read_clear: assert property ((cfg_ff[3] && src_rd) ##1 (!sample_stb) [*3] ##0 src_rd
      |=> prdata[7:0] == 8'h00)
      else $error("held flags survive a read");
   chk_mode_clear: assert property ((op_mode == 2'h2 && $past(op_mode) != 2'h2) ##1 !sample_stb
      ##1 (src_rd && !sample_stb) |=> prdata[7:0] == 8'h00)
      else $error("source not cleared on active entry");
   chk_irq_masked: assert property (mask_ff == 3'h0 |-> !irq)
      else $error("interrupt high with all masked");
endmodule // rtes_sva

// *** tb/rtes_test.sv ***
`timescale 1ns/100ps
// Self-checking bench for the rate event source block
module rtes_test;
   logic               pclk;
   logic               presetn;
   logic [7:0]         paddr;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [1:0]         op_mode;
   logic               sample_stb;
   logic signed [15:0] rate_v [3];
   logic               irq;
   logic [31:0]        d;
   logic               e;
   logic [3:0]         cfg;
   logic [7:0]         lim;
   logic [7:0]         len;
   int                 n_mismatch;
   int                 n_compared;
   int                 seed;
   int                 cnt [3];
   bit                 ev [3];
   bit                 ht [3];
   bit                 hs [3];
   bit                 ls [3];
   logic [5:0]         ridx [6];
   logic [7:0]         rexp [6];

   rtes_top #(.RATE_W(16)) rtes_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_mode(op_mode), .sample_stb(sample_stb),
      .rate_x(rate_v[0]), .rate_y(rate_v[1]), .rate_z(rate_v[2]), .irq(irq));

   // Clock at 20 MHz
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      check_reg({31'h0, got}, {31'h0, exp});
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [5:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      paddr  <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= wd;
      psel   <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Expected source byte from the bench model
   function automatic logic [7:0] src_exp();
      logic [7:0] v;
      v = 8'h00;
      for (int k = 0; k < 3; k++) begin
         if (cfg[k]) begin
            v[2*k+1] = cfg[3] ? ht[k] : ev[k];
            v[2*k]   = cfg[3] ? hs[k] : ls[k];
         end
      end
      v[6] = v[1] | v[3] | v[5];
      return v;
   endfunction

   // Debounce model of one axis after a sample
   function automatic void step(input int k, input int r);
      bit up;
      up = ((r < 0) ? -r : r) > (lim[6:0] + 1) * 256;
      if (cfg[k]) begin
         if (up) cnt[k] = (cnt[k] < len) ? cnt[k] + 1 : cnt[k];
         else cnt[k] = (lim[7] || cnt[k] == 0) ? 0 : cnt[k] - 1;
         if (up && cnt[k] >= len) begin
            ht[k] = ht[k] | !ev[k];
            ev[k] = 1'b1;
         end else if (!up && cnt[k] == 0) ev[k] = 1'b0;
         ls[k] = r < 0;
         hs[k] = hs[k] | (r < 0);
      end
   endfunction

   // Random rates at or just above the limit, below 1024, or full-scale negative, then one sample tick
   task automatic sample_all();
      int r [3];
      int thr;
      thr = (lim[6:0] + 1) * 256;
      for (int k = 0; k < 3; k++) begin
         case ($random(seed) & 3)
            0: r[k] = thr;
            1: r[k] = thr + 1;
            2: r[k] = $random(seed) & 16'h3ff;
            default: r[k] = -32768;
         endcase
         if (r[k] != -32768 && ($random(seed) & 1)) r[k] = -r[k];
      end
      @(posedge pclk);
      for (int k = 0; k < 3; k++) rate_v[k] <= r[k][15:0];
      sample_stb <= 1'b1;
      @(posedge pclk);
      sample_stb <= 1'b0;
      for (int k = 0; k < 3; k++) step(k, r[k]);
   endtask

   // Watchdog
   initial begin
      #(50 * 40000);
      n_mismatch++;
      finish_test();
   end

   // Main sequence
   initial begin
      {psel, penable, pwrite, sample_stb, paddr, pwdata, op_mode} = '0;
      rate_v = '{16'sh0, 16'sh0, 16'sh0};
      n_mismatch = 0;
      n_compared = 0;
      seed = 32'h211b;
      ridx = '{rtes_pkg::IDX_CONFIG, rtes_pkg::IDX_SOURCE, rtes_pkg::IDX_LIMIT,
               rtes_pkg::IDX_DEBOUNCE, rtes_pkg::IDX_IRQ_STATUS, rtes_pkg::IDX_IRQ_MASK};
      rexp = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(ridx[i], 1'b0, 32'h0, d, e);
         check_reg(d, {24'h0, rexp[i]}); // Reset value
      end
      apb(6'h3f, 1'b0, 32'h0, d, e);
      check_flag(e, 1'b1);
      check_flag(pready, 1'b1);
      apb(rtes_pkg::IDX_SOURCE, 1'b1, 32'hff, d, e);
      apb(rtes_pkg::IDX_SOURCE, 1'b0, 32'h0, d, e);
      check_reg(d, 32'h0); // Write ignored
      for (int p = 0; p < 14; p++) begin
         @(posedge pclk);
         op_mode <= 2'h0;
         cfg = $random(seed);
         lim = $random(seed) & 8'h8f;
         len = $random(seed) & 3;
         apb(rtes_pkg::IDX_CONFIG, 1'b1, {28'h0, cfg}, d, e);
         apb(rtes_pkg::IDX_LIMIT, 1'b1, {24'h0, lim}, d, e);
         apb(rtes_pkg::IDX_DEBOUNCE, 1'b1, {24'h0, len}, d, e);
         @(posedge pclk);
         op_mode <= {1'b0, p[0]};
         @(posedge pclk);
         op_mode <= 2'h2;
         @(posedge pclk);
         for (int k = 0; k < 3; k++) begin
            cnt[k] = 0;
            ev[k] = 0;
            ht[k] = 0;
            hs[k] = 0;
            ls[k] = 0;
         end
         apb(rtes_pkg::IDX_SOURCE, 1'b0, 32'h0, d, e);
         check_reg(d, 32'h0); // Cleared on entry
         for (int s = 0; s < 16; s++) begin
            sample_all();
            for (int i = 0; i < 2; i++) begin
               apb(rtes_pkg::IDX_SOURCE, 1'b0, 32'h0, d, e);
               check_reg(d, {24'h0, src_exp()}); // Src
               if (cfg[3]) begin
                  ht = '{0, 0, 0};
                  hs = '{0, 0, 0};
               end
            end
         end
      end
      // Interrupt raised, masked and cleared; detection off first so no trip is left live
      apb(rtes_pkg::IDX_CONFIG, 1'b1, 32'h0, d, e);
      apb(rtes_pkg::IDX_CONFIG, 1'b1, 32'h1, d, e);
      apb(rtes_pkg::IDX_LIMIT, 1'b1, 32'h0, d, e);
      apb(rtes_pkg::IDX_DEBOUNCE, 1'b1, 32'h0, d, e);
      apb(rtes_pkg::IDX_IRQ_STATUS, 1'b1, 32'h7, d, e);
      apb(rtes_pkg::IDX_IRQ_MASK, 1'b1, 32'h7, d, e);
      @(negedge pclk);
      check_flag(irq, 1'b0);
      @(posedge pclk);
      rate_v[0] <= 16'sd300;
      sample_stb <= 1'b1;
      @(posedge pclk);
      sample_stb <= 1'b0;
      repeat (3) @(negedge pclk);
      check_flag(irq, 1'b1); // X trip on first sample above
      apb(rtes_pkg::IDX_IRQ_STATUS, 1'b0, 32'h0, d, e);
      check_reg(d, 32'h1);
      apb(rtes_pkg::IDX_IRQ_MASK, 1'b1, 32'h0, d, e);
      @(negedge pclk);
      check_flag(irq, 1'b0);
      apb(rtes_pkg::IDX_IRQ_MASK, 1'b1, 32'h7, d, e);
      @(negedge pclk);
      check_flag(irq, 1'b1);
      apb(rtes_pkg::IDX_IRQ_STATUS, 1'b1, 32'h1, d, e);
      @(negedge pclk);
      check_flag(irq, 1'b0);
      finish_test();
   end
endmodule // rtes_test

bind rtes_top rtes_sva rtes_sva_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .op_mode(op_mode),
   .sample_stb(sample_stb), .irq(irq));
